// *** src/divsqrt_pkg.sv ***
// constants shared by the divide / square-root datapath
// assumes a single 100 MHz clock and an active-low asynchronous reset
//
// Summary of operation
// RQ1: the master only ever issues full 32-bit word operands and results.
// RQ2: a division finishes in exactly 8 clock cycles, results appear only then.
// RQ3: division takes 32-bit dividend and divisor, gives 32-bit quotient and remainder.
// RQ4: a division started with a zero divisor raises a readable warning flag.
// RQ5: the end of a division raises a readable completion flag.
// RQ6: square root takes a 32-bit radicand and gives a 16-bit root.
// RQ7: a square root finishes in exactly 8 clock cycles.
// RQ8: completion shows as an interrupt when enabled, else through polled status.
// RQ9: results and flags hold until the next start; start clears completion.
package divsqrt_pkg;

    // ------------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------------
    localparam int DATA_W              = 32;
    localparam int ROOT_W              = 16;
    localparam int OP_CYCLES           = 8;
    localparam int DIV_BITS_PER_CYCLE  = DATA_W / OP_CYCLES;
    localparam int ROOT_CALCULATOR_BITS_PER_CYCLE = ROOT_W / OP_CYCLES;
    localparam int CNT_W               = $clog2(OP_CYCLES);
    localparam logic [CNT_W-1:0] LAST_STEP = CNT_W'(OP_CYCLES - 1);

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [ROOT_W-1:0] ROOT_ZERO = 16'h0000;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } seq_state_e;

endpackage

// *** src/arith_step.sv ***
// one cycle worth of restoring division or square-root iterations
// purely combinational; the caller registers every output
`timescale 1ns/1ns
`default_nettype none
module arith_step #(
    parameter int DIV_BITS  = 4,
    parameter int ROOT_CALCULATOR_BITS = 2
) (
    // operation select
    input  wire logic        mode_root_calculator,
    // state in
    input  wire logic [31:0] acc_i,
    input  wire logic [31:0] work_i,
    input  wire logic [31:0] quo_i,
    input  wire logic [31:0] divisor_i,
    // state out
    output logic      [31:0] acc_o,
    output logic      [31:0] work_o,
    output logic      [31:0] quo_o
);

    always_comb begin
        logic [33:0] r;
        logic [33:0] t;
        logic [31:0] w;
        logic [31:0] q;
        r = {2'b00, acc_i};
        t = {2'b00, divisor_i};
        w = work_i;
        q = quo_i;
        if (!mode_root_calculator) begin
            // divisor of zero always subtracts: quotient all ones, remainder dividend
            for (int i = 0; i < DIV_BITS; i++) begin
                r = {r[32:0], w[31]};
                w = {w[30:0], 1'b0};
                if (r >= t) begin
                    r = r - t;
                    q = {q[30:0], 1'b1};
                end else begin
                    q = {q[30:0], 1'b0};
                end
            end
        end else begin
            for (int i = 0; i < ROOT_CALCULATOR_BITS; i++) begin
                r = {r[31:0], w[31:30]};
                w = {w[29:0], 2'b00};
                t = {q, 2'b01};
                if (r >= t) begin
                    r = r - t;
                    q = {q[30:0], 1'b1};
                end else begin
                    q = {q[30:0], 1'b0};
                end
            end
        end
        // remainder never exceeds 32 bits for either operation
        acc_o  = r[31:0];
        work_o = w;
        quo_o  = q;
    end

endmodule
`default_nettype wire

// *** src/divider_root_calculator_unit.sv ***
// hw_divider and root_calculator datapath with start, status and interrupt
// assumes operands are valid on the edge that takes START; no software bus here
`timescale 1ns/1ns
`default_nettype none
module divider_root_calculator_unit
    import divsqrt_pkg::*;
(
    // clock and reset
    input  wire logic                           CLK,
    input  wire logic                           RSTN,
    // command
    input  wire logic                           START,
    input  wire logic                           OP_ROOT_CALCULATOR,
    input  wire logic                           INT_EN,
    // operands, full words only
    input  wire logic [divsqrt_pkg::DATA_W-1:0] DIVIDEND,
    input  wire logic [divsqrt_pkg::DATA_W-1:0] DIVISOR,
    // results
    output logic      [divsqrt_pkg::DATA_W-1:0] QUOTIENT,
    output logic      [divsqrt_pkg::DATA_W-1:0] REMAINDER,
    output logic      [divsqrt_pkg::ROOT_W-1:0] ROOT,
    // status
    output logic                                BUSY,
    output logic                                DONE,
    output logic                                DIV_ZERO,
    output logic                                IRQ
);
    import divsqrt_pkg::*;

    seq_state_e         state_q;
    logic [CNT_W-1:0]   cnt_q;
    logic               mode_q;
    logic [DATA_W-1:0]  acc_q;
    logic [DATA_W-1:0]  work_q;
    logic [DATA_W-1:0]  quo_q;
    logic [DATA_W-1:0]  div_q;
    logic [DATA_W-1:0]  acc_d;
    logic [DATA_W-1:0]  work_d;
    logic [DATA_W-1:0]  quo_d;
    logic               take;
    logic               finish;

    // start while busy is ignored so a running result cannot be corrupted
    assign take   = START && (state_q == ST_IDLE);
    assign finish = (state_q == ST_RUN) && (cnt_q == LAST_STEP);

    // ------------------------------------------------------------------
    // iteration datapath
    // ------------------------------------------------------------------
    arith_step #(
        .DIV_BITS  (DIV_BITS_PER_CYCLE),
        .ROOT_CALCULATOR_BITS (ROOT_CALCULATOR_BITS_PER_CYCLE)
    ) u_step (
        .mode_root_calculator (mode_q),
        .acc_i     (acc_q),
        .work_i    (work_q),
        .quo_i     (quo_q),
        .divisor_i (div_q),
        .acc_o     (acc_d),
        .work_o    (work_d),
        .quo_o     (quo_d)
    );

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            BUSY    <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    cnt_q <= '0;
                    if (take) begin
                        state_q <= ST_RUN;
                        BUSY    <= 1'b1;
                    end
                end
                ST_RUN: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (finish) begin                   // [RQ2] [RQ7]
                        state_q <= ST_IDLE;
                        BUSY    <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // working registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_q <= 1'b0;
            acc_q  <= WORD_ZERO;
            work_q <= WORD_ZERO;
            quo_q  <= WORD_ZERO;
            div_q  <= WORD_ZERO;
        end else if (take) begin
            mode_q <= OP_ROOT_CALCULATOR;                          // [RQ3] [RQ6]
            acc_q  <= WORD_ZERO;
            work_q <= DIVIDEND;
            quo_q  <= WORD_ZERO;
            div_q  <= DIVISOR;
        end else if (state_q == ST_RUN) begin
            acc_q  <= acc_d;
            work_q <= work_d;
            quo_q  <= quo_d;
        end
    end

    // ------------------------------------------------------------------
    // result registers, each held until the next operation of its own kind ends
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            QUOTIENT  <= WORD_ZERO;
            REMAINDER <= WORD_ZERO;
            ROOT      <= ROOT_ZERO;
        end else if (finish) begin
            if (mode_q) begin
                ROOT <= quo_d[ROOT_W-1:0];              // [RQ6] [RQ9]
            end else begin
                QUOTIENT  <= quo_d;                     // [RQ3] [RQ9]
                REMAINDER <= acc_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DONE     <= 1'b0;
            DIV_ZERO <= 1'b0;
        end else if (take) begin
            DONE     <= 1'b0;                           // [RQ9]
            DIV_ZERO <= !OP_ROOT_CALCULATOR && (DIVISOR == WORD_ZERO); // [RQ4]
        end else if (finish) begin
            DONE     <= 1'b1;                           // [RQ5] [RQ8]
        end
    end

    // interrupt follows completion one cycle later while enabled
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= DONE && INT_EN;                      // [RQ8]
        end
    end

endmodule
`default_nettype wire

// *** sim/divsqrt_properties.sv ***
// port assertions for the divide / root unit
// bound onto every divider_root_calculator_unit instance
`timescale 1ns/1ns
`default_nettype none
module divsqrt_properties (
    input wire logic        CLK, RSTN, START, OP_ROOT_CALCULATOR, INT_EN,
    input wire logic [31:0] DIVIDEND, DIVISOR, QUOTIENT, REMAINDER,
    input wire logic [15:0] ROOT,
    input wire logic        BUSY, DONE, DIV_ZERO, IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    wire logic go = START && !BUSY;
    property p_lat; go |=> !DONE [*8] ##1 DONE; endproperty
    a_lat: assert property (p_lat) else $error("done late");
    property p_busy; go |=> BUSY [*8] ##1 !BUSY; endproperty
    a_busy: assert property (p_busy) else $error("busy span");
    property p_dz; go && !OP_ROOT_CALCULATOR && DIVISOR == '0 |=> DIV_ZERO; endproperty
    a_dz: assert property (p_dz) else $error("no zero flag");
    property p_hold; !BUSY && !go |=> $stable({QUOTIENT, REMAINDER, ROOT, DONE, DIV_ZERO});
    endproperty
    a_hold: assert property (p_hold) else $error("idle change");
    property p_irq; $rose(DONE) && INT_EN |=> IRQ; endproperty
    a_irq: assert property (p_irq) else $error("no irq");
    property p_noirq; !INT_EN |=> !IRQ; endproperty
    a_noirq: assert property (p_noirq) else $error("masked irq");
    property p_div; go && !OP_ROOT_CALCULATOR && DIVISOR != '0 |-> ##9
        QUOTIENT == $past(DIVIDEND, 9) / $past(DIVISOR, 9) &&
        REMAINDER == $past(DIVIDEND, 9) % $past(DIVISOR, 9); endproperty
    a_div: assert property (p_div) else $error("bad quotient");
    property p_root; go && OP_ROOT_CALCULATOR |-> ##9 64'(ROOT) * ROOT <= $past(DIVIDEND, 9) &&
        (64'(ROOT) + 1) ** 2 > $past(DIVIDEND, 9); endproperty
    a_root: assert property (p_root) else $error("bad root");
endmodule
bind divider_root_calculator_unit divsqrt_properties divsqrt_properties_inst (.CLK, .RSTN, .START,
    .OP_ROOT_CALCULATOR, .INT_EN, .DIVIDEND, .DIVISOR, .QUOTIENT, .REMAINDER, .ROOT, .BUSY, .DONE,
    .DIV_ZERO, .IRQ);
`default_nettype wire

// *** sim/core_model.sv ***
// core-side model: issues one operation, polls completion
// operands valid only on the taking edge, scrambled after
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input wire logic     CLK, BUSY, DONE,
    output logic         START, OP_ROOT_CALCULATOR, INT_EN,
    output logic [31:0]  DIVIDEND, DIVISOR
);
    initial {START, OP_ROOT_CALCULATOR, INT_EN, DIVIDEND, DIVISOR} = '0;
    // pk re-raises start while busy; the unit must ignore it
    task automatic issue(input logic s, e, input logic [31:0] a, b, input int gap,
                         input logic pk);
        repeat (gap) @(posedge CLK);
        @(posedge CLK);
        START <= 1'b1;
        OP_ROOT_CALCULATOR <= s;
        INT_EN <= e;
        DIVIDEND <= a;
        DIVISOR <= b;
        @(posedge CLK);
        // hold the request until it meets an idle edge
        while (BUSY) @(posedge CLK);
        START <= pk;
        DIVIDEND <= ~a;
        DIVISOR <= ~b;
        @(posedge CLK);
        START <= 1'b0;
        repeat (12) begin
            @(negedge CLK);
            if (DONE) break;
        end
    endtask
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench: directed and random divide / root operations
// needs core_model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        CLK = 1'b0, RSTN = 1'b0, pd = 1'b0, ei;
    logic        START, OP_ROOT_CALCULATOR, INT_EN, BUSY, DONE, DIV_ZERO, IRQ;
    logic [31:0] DIVIDEND, DIVISOR, QUOTIENT, REMAINDER, r, s = 32'h39, eq = '0, er = '0;
    logic [15:0] ROOT, et = '0;
    logic [80:0] exq[$];
    int          fail_count = 0, n_tests = 0;
    always #5 CLK = ~CLK;
    divider_root_calculator_unit divider_root_calculator_unit_inst (.CLK, .RSTN, .START, .OP_ROOT_CALCULATOR, .INT_EN,
        .DIVIDEND, .DIVISOR, .QUOTIENT, .REMAINDER, .ROOT, .BUSY, .DONE, .DIV_ZERO, .IRQ);
    core_model core_model_inst (.CLK, .BUSY, .DONE, .START, .OP_ROOT_CALCULATOR, .INT_EN, .DIVIDEND,
        .DIVISOR);
    function automatic logic [31:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [80:0] v, x);
        n_tests++;
        if (v !== x) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, v, x);
        end
    endtask
    task automatic op(input logic sq, input logic [31:0] a, b, input int gap, input logic pk);
        logic [63:0] x, y;
        x = '0;
        if (sq) begin
            for (int i = 15; i >= 0; i--) begin
                y = x | (64'h1 << i);
                if (y * y <= a) x = y;
            end
            et = x[15:0];
        end else if (b == '0) begin
            eq = '1;
            er = a;
        end else begin
            eq = a / b;
            er = a % b;
        end
        exq.push_back({!sq && b == '0, et, eq, er});
        r = rnd();
        core_model_inst.issue(sq, r[0], a, b, gap, pk);
    endtask
    always @(negedge CLK) begin
        if (DONE && !pd) begin
            chk({DIV_ZERO, ROOT, QUOTIENT, REMAINDER}, exq.pop_front());
            ei = INT_EN;
            @(negedge CLK);
            chk(IRQ, ei);
        end
        pd = DONE;
    end
    task print_verdict();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        @(negedge CLK);
        chk({DIV_ZERO, ROOT, QUOTIENT, REMAINDER}, '0);
        chk({BUSY, DONE, IRQ}, '0);
        op(1'b0, 32'h64, 32'h7, 0, 1'b0);
        op(1'b0, 32'h3, 32'hA, 0, 1'b1);
        op(1'b0, 32'h1234_5678, '0, 0, 1'b0);
        op(1'b1, '1, 32'h5, 0, 1'b1);
        op(1'b1, 32'h1_0000, '0, 1, 1'b0);
        op(1'b0, '1, 32'h1, 2, 1'b0);
        repeat (24) begin
            r = rnd();
            op(r[0], rnd(), r[2:1] == 2'h0 ? '0 : rnd() >> r[8:4], int'(r[10:9]), r[11]);
        end
        repeat (20) @(negedge CLK);
        chk(exq.size(), '0);
        print_verdict();
    end
endmodule
`default_nettype wire
